/* src/tsc_pkg.sv */
// constants and types for the touch sampling and timing controller
// assumes one 40 MHz clock; all long times run off a 10 us tick
package tsc_pkg;

  // clock and tick
  localparam int CLK_MHZ = 40;
  localparam int TICK_US = 10;
  localparam int TICK_CYCLES = CLK_MHZ * TICK_US;

  // documented times, in their own units, and their tick counts
  localparam int TIME_UNIT_MS = 35;
  localparam int SAMP_LONG_US = 2560;
  localparam int SAMP_SHORT_US = 1280;
  localparam int RECAL_MS = 600;
  localparam logic [15:0] UNIT_TICKS = 16'(TIME_UNIT_MS * 1000 / TICK_US);
  localparam logic [8:0] SAMP_LONG_TICKS = 9'(SAMP_LONG_US / TICK_US);
  localparam logic [8:0] SAMP_SHORT_TICKS = 9'(SAMP_SHORT_US / TICK_US);
  localparam logic [15:0] RECAL_TICKS = 16'(RECAL_MS * 1000 / TICK_US);

  // register offsets
  localparam logic [7:0] ADDR_SENS_EN = 8'h21;
  localparam logic [7:0] ADDR_SENS_CFG = 8'h22;
  localparam logic [7:0] ADDR_HOLD = 8'h23;
  localparam logic [7:0] ADDR_AVG = 8'h24;
  localparam logic [7:0] ADDR_RECAL = 8'h26;
  localparam logic [7:0] ADDR_RPT_EN = 8'h28;
  localparam logic [7:0] ADDR_STATUS = 8'h30;
  localparam logic [7:0] ADDR_MASK = 8'h31;

  // reset values
  localparam logic [7:0] RST_SENS_EN = 8'hFF;
  localparam logic [7:0] RST_SENS_CFG = 8'hA4;
  localparam logic [7:0] RST_HOLD = 8'h07;
  localparam logic [7:0] RST_AVG = 8'h1D;
  localparam logic [7:0] RST_RECAL = 8'hFF;
  localparam logic [7:0] RST_RPT_EN = 8'hFF;
  localparam logic [7:0] RST_MASK = 8'hFF;

  // field positions
  localparam int CODE_LSB = 0;
  localparam int AVG_LSB = 3;
  localparam int SAMP_SEL_BIT = 2;
  localparam int CYC_LSB = 0;

  // sequencer phases
  typedef enum logic {TSC_WAIT, TSC_SAMPLE} tsc_phase_type;

  // whole state of the controller
  typedef struct packed {
    logic [15:0] div;
    logic tick;
    logic [7:0] sens_en;
    logic [7:0] sens_cfg;
    logic [7:0] hold_cfg;
    logic [7:0] avg_cfg;
    logic [7:0] recal;
    logic [7:0] rpt_en;
    logic [7:0] status;
    logic [7:0] mask;
    logic [7:0] rdata;
    tsc_phase_type phase;
    logic [2:0] chan;
    logic [8:0] samp_t;
    logic [7:0] samp_n;
    logic [22:0] acc;
    logic [19:0] cyc;
    logic meas_valid;
    logic [2:0] meas_chan;
    logic [15:0] meas_value;
    logic [7:0] touch_prev;
    logic [7:0] hold;
    logic [7:0] plain;
    logic [7:0] evt;
    logic [7:0][15:0] held;
    logic [7:0][15:0] rptc;
    logic [7:0][15:0] recal_t;
  } tsc_state_type;

endpackage : tsc_pkg

/* src/tsc_ctrl.sv */
// touch sampling sequencer, hold classifier and recalibration timer
// assumes touch_detect and sample_value are synchronous to ref_clk and
// that the analog front end converts while sample_active is high
//
// Our own choice: the plain strobed port.
module tsc_ctrl #(
  parameter int TICK_CYCLES = tsc_pkg::TICK_CYCLES
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // analog front end
  input wire logic [7:0] touch_detect,
  input wire logic [15:0] sample_value,
  output logic sample_active,
  output logic [2:0] sample_chan,
  output logic low_power,
  // measurement results
  output logic meas_valid,
  output logic [2:0] meas_chan,
  output logic [15:0] meas_value,
  // touch classification
  output logic [7:0] press_hold,
  output logic [7:0] plain_touch,
  output logic [7:0] base_invalid,
  // interrupt
  output logic irq
);

  localparam logic [15:0] TICK_M1 = 16'(TICK_CYCLES - 1);

  tsc_pkg::tsc_state_type r, n;

  // decoded timing values
  logic [15:0] hold_ticks;
  logic [15:0] rpt_ticks;
  logic [19:0] cyc_ticks;
  logic [8:0] samp_ticks;
  logic [7:0] n_samples;
  logic [2:0] avg_code;

  // code to 35 ms multiples, in ticks
  function automatic logic [15:0] tsc_code_ticks(input logic [3:0] code);
    return 16'((32'(code) + 32'd1) * 32'(tsc_pkg::UNIT_TICKS));
  endfunction : tsc_code_ticks

  // lowest enabled channel at or above from; bit 3 says found
  function automatic logic [3:0] tsc_next_en(input logic [7:0] en,
                                             input logic [3:0] from);
    logic [3:0] res;
    res = 4'h0;
    for (int j = 7; j >= 0; j--) begin
      if (en[j] && 4'(j) >= from) begin
        res = {1'b1, 3'(j)};
      end
    end
    return res;
  endfunction : tsc_next_en

  // field decode
  always_comb begin
    hold_ticks = tsc_code_ticks(r.hold_cfg[tsc_pkg::CODE_LSB +: 4]);
    rpt_ticks = tsc_code_ticks(r.sens_cfg[tsc_pkg::CODE_LSB +: 4]);
    cyc_ticks = 20'(tsc_code_ticks({2'b00,
                r.avg_cfg[tsc_pkg::CYC_LSB +: 2]}));
    samp_ticks = r.avg_cfg[tsc_pkg::SAMP_SEL_BIT] ?
                 tsc_pkg::SAMP_SHORT_TICKS : tsc_pkg::SAMP_LONG_TICKS;
    avg_code = r.avg_cfg[tsc_pkg::AVG_LSB +: 3];
    n_samples = 8'h01 << avg_code;
  end

  // next state
  always_comb begin
    logic [7:0] touch_eff;
    logic [7:0] rise;
    logic [7:0] fall;
    logic [7:0] ev_rpt;
    logic [7:0] ev_plain;
    logic [3:0] nx;
    logic [22:0] acc_sum;
    touch_eff = 8'h00;
    rise = 8'h00;
    fall = 8'h00;
    ev_rpt = 8'h00;
    ev_plain = 8'h00;
    nx = 4'h0;
    acc_sum = 23'h000000;
    n = r;

    // tick divider, every slower rate derives from it
    n.tick = 1'b0;
    if (r.div >= TICK_M1) begin
      n.div = 16'h0000;
      n.tick = 1'b1;
    end else begin
      n.div = r.div + 16'h0001;
    end

    // register writes; reserved bits stay zero
    if (reg_wr) begin
      case (reg_addr)
        tsc_pkg::ADDR_SENS_EN: n.sens_en = reg_wdata;
        tsc_pkg::ADDR_SENS_CFG: n.sens_cfg = reg_wdata;
        tsc_pkg::ADDR_HOLD: n.hold_cfg = {4'h0, reg_wdata[3:0]};
        tsc_pkg::ADDR_AVG: n.avg_cfg = {2'b00, reg_wdata[5:0]};
        tsc_pkg::ADDR_RPT_EN: n.rpt_en = reg_wdata;
        tsc_pkg::ADDR_MASK: n.mask = reg_wdata;
        default: ; // recal and status handled below
      endcase
    end

    // read data stands only in the cycle after the strobe
    n.rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        tsc_pkg::ADDR_SENS_EN: n.rdata = r.sens_en;
        tsc_pkg::ADDR_SENS_CFG: n.rdata = r.sens_cfg;
        tsc_pkg::ADDR_HOLD: n.rdata = r.hold_cfg;
        tsc_pkg::ADDR_AVG: n.rdata = r.avg_cfg;
        tsc_pkg::ADDR_RECAL: n.rdata = r.recal;
        tsc_pkg::ADDR_RPT_EN: n.rdata = r.rpt_en;
        tsc_pkg::ADDR_STATUS: n.rdata = r.status;
        tsc_pkg::ADDR_MASK: n.rdata = r.mask;
        default: n.rdata = 8'h00; // unmapped reads as zero
      endcase
    end

    // a recalibrating sensor sees no press at all
    touch_eff = touch_detect & ~r.recal;
    rise = touch_eff & ~r.touch_prev;
    fall = r.touch_prev & ~touch_eff & ~r.recal;
    n.touch_prev = touch_eff;

    // per channel press timing and classification
    for (int i = 0; i < 8; i++) begin
      if (rise[i]) begin
        n.held[i] = 16'h0000;
        n.rptc[i] = 16'h0000;
        n.hold[i] = 1'b0;
      end else if (touch_eff[i] && r.tick) begin
        // saturate so a very long hold never wraps back to a touch
        if (r.held[i] != 16'hFFFF) begin
          n.held[i] = r.held[i] + 16'h0001;
        end
        if (r.hold[i]) begin
          // repeat interrupt each interval while held
          if (r.rptc[i] >= rpt_ticks - 16'h0001) begin
            n.rptc[i] = 16'h0000;
            ev_rpt[i] = 1'b1;
          end else begin
            n.rptc[i] = r.rptc[i] + 16'h0001;
          end
        end else if (r.rpt_en[i] && r.held[i] >= hold_ticks) begin
          n.hold[i] = 1'b1;
        end
      end
      if (fall[i]) begin
        n.hold[i] = 1'b0;
        // held not beyond threshold: plain touch, release interrupts
        ev_plain[i] = ~r.hold[i];
      end
      if (r.recal[i]) begin
        n.hold[i] = 1'b0;
      end
    end
    n.plain = ev_plain;
    n.evt = rise | ev_rpt | ev_plain;

    // recalibration timers, one per sense input
    for (int i = 0; i < 8; i++) begin
      if (r.recal[i]) begin
        if (touch_detect[i]) begin
          n.recal_t[i] = 16'h0000;
        end else if (r.tick) begin
          if (r.recal_t[i] >= tsc_pkg::RECAL_TICKS - 16'h0001) begin
            n.recal[i] = 1'b0;
            n.recal_t[i] = 16'h0000;
          end else begin
            n.recal_t[i] = r.recal_t[i] + 16'h0001;
          end
        end
      end
    end
    // software may only set request bits, and a set beats the clear
    if (reg_wr && reg_addr == tsc_pkg::ADDR_RECAL) begin
      for (int i = 0; i < 8; i++) begin
        if (reg_wdata[i] && !r.recal[i]) begin
          n.recal_t[i] = 16'h0000;
        end
      end
      n.recal = n.recal | reg_wdata;
    end

    // sticky status, write one to clear, new event wins
    if (reg_wr && reg_addr == tsc_pkg::ADDR_STATUS) begin
      n.status = r.status & ~reg_wdata;
    end
    n.status = n.status | n.evt;

    // cycle timer saturates so a stretched cycle restarts at once
    n.meas_valid = 1'b0;
    if (r.tick && r.cyc != 20'hFFFFF) begin
      n.cyc = r.cyc + 20'h00001;
    end

    // sampling sequencer
    unique case (r.phase)
      tsc_pkg::TSC_WAIT: begin
        // low power for the rest of the cycle
        if (r.cyc >= cyc_ticks) begin
          n.cyc = 20'h00000;
          nx = tsc_next_en(r.sens_en, 4'h0);
          if (nx[3]) begin
            n.phase = tsc_pkg::TSC_SAMPLE;
            n.chan = nx[2:0];
            n.samp_t = 9'h000;
            n.samp_n = 8'h00;
            n.acc = 23'h000000;
          end
        end
      end
      tsc_pkg::TSC_SAMPLE: begin
        if (r.tick) begin
          if (r.samp_t >= samp_ticks - 9'h001) begin
            n.samp_t = 9'h000;
            acc_sum = r.acc + 23'(sample_value);
            if (r.samp_n >= n_samples - 8'h01) begin
              // average by shift then move to the next channel
              n.meas_valid = 1'b1;
              n.meas_chan = r.chan;
              n.meas_value = 16'(acc_sum >> avg_code);
              n.acc = 23'h000000;
              n.samp_n = 8'h00;
              nx = tsc_next_en(r.sens_en, {1'b0, r.chan} + 4'h1);
              if (nx[3]) begin
                n.chan = nx[2:0];
              end else begin
                // an overrun leaves cyc past the period, restart next
                n.phase = tsc_pkg::TSC_WAIT;
              end
            end else begin
              n.acc = acc_sum;
              n.samp_n = r.samp_n + 8'h01;
            end
          end else begin
            n.samp_t = r.samp_t + 9'h001;
          end
        end
      end
    endcase
  end

  // state register; cyc starts saturated so sampling begins at once
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      r <= '0;
      r.sens_en <= tsc_pkg::RST_SENS_EN;
      r.sens_cfg <= tsc_pkg::RST_SENS_CFG;
      r.hold_cfg <= tsc_pkg::RST_HOLD;
      r.avg_cfg <= tsc_pkg::RST_AVG;
      r.recal <= tsc_pkg::RST_RECAL;
      r.rpt_en <= tsc_pkg::RST_RPT_EN;
      r.mask <= tsc_pkg::RST_MASK;
      r.cyc <= 20'hFFFFF;
      r.phase <= tsc_pkg::TSC_WAIT;
    end else begin
      r <= n;
    end
  end

  // outputs, all straight from state
  assign reg_rdata = r.rdata;
  assign sample_active = (r.phase == tsc_pkg::TSC_SAMPLE);
  assign sample_chan = r.chan;
  assign low_power = (r.phase == tsc_pkg::TSC_WAIT);
  assign meas_valid = r.meas_valid;
  assign meas_chan = r.meas_chan;
  assign meas_value = r.meas_value;
  assign press_hold = r.hold;
  assign plain_touch = r.plain;
  assign base_invalid = r.recal;
  assign irq = |(r.status & r.mask);

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_recal_write;
    reg_wr && reg_addr == tsc_pkg::ADDR_RECAL;
  endsequence
  sequence s_sample_end;
    r.phase == tsc_pkg::TSC_SAMPLE ##1 r.meas_valid;
  endsequence

  property p_recal_set;
    s_recal_write |=> ((r.recal & $past(reg_wdata)) == $past(reg_wdata));
  endproperty
  a_recal_set: assert property (p_recal_set)
    else $error("recal request bit not held after write");

  property p_recal_done;
    $fell(r.recal[0]) |->
      $past(r.recal_t[0]) == tsc_pkg::RECAL_TICKS - 16'h0001 &&
      !$past(touch_detect[0]);
  endproperty
  a_recal_done: assert property (p_recal_done)
    else $error("recal bit cleared before full quiet period");

  property p_recal_press;
    r.recal[7] && touch_detect[7] |=> r.recal[7] && r.recal_t[7] == 0;
  endproperty
  a_recal_press: assert property (p_recal_press)
    else $error("press during recal did not restart it");

  property p_recal_mute;
    r.recal[7] ##1 r.recal[7] |-> !r.evt[7] && !r.hold[7];
  endproperty
  a_recal_mute: assert property (p_recal_mute)
    else $error("event on a recalibrating sensor");

  property p_hold_entry;
    $rose(r.hold[0]) |->
      r.held[0] > $past(hold_ticks) && $past(r.rpt_en[0]);
  endproperty
  a_hold_entry: assert property (p_hold_entry)
    else $error("press and hold declared too early");

  property p_plain;
    r.plain[0] |-> $past(r.touch_prev[0]) && !$past(r.hold[0]) &&
      (!$past(r.rpt_en[0]) || $past(r.held[0]) <= $past(hold_ticks));
  endproperty
  a_plain: assert property (p_plain)
    else $error("plain touch after hold threshold");

  property p_no_release_int;
    r.hold[0] && !touch_detect[0] && !r.recal[0] |=> !r.evt[0];
  endproperty
  a_no_release_int: assert property (p_no_release_int)
    else $error("interrupt on release after press and hold");

  property p_cycle_wait;
    r.phase == tsc_pkg::TSC_WAIT && r.cyc < cyc_ticks
      |=> r.phase == tsc_pkg::TSC_WAIT;
  endproperty
  a_cycle_wait: assert property (p_cycle_wait)
    else $error("sampling started before cycle period ended");

  property p_overrun;
    r.phase == tsc_pkg::TSC_WAIT && r.cyc >= cyc_ticks && r.sens_en != 0
      |=> r.phase == tsc_pkg::TSC_SAMPLE && r.cyc == 0;
  endproperty
  a_overrun: assert property (p_overrun)
    else $error("cycle not restarted after period");

  property p_avg;
    s_sample_end |-> $past(r.samp_n) == $past(n_samples) - 8'h01;
  endproperty
  a_avg: assert property (p_avg)
    else $error("measurement with wrong sample count");

  property p_sample_len;
    r.phase == tsc_pkg::TSC_SAMPLE |-> r.samp_t < samp_ticks;
  endproperty
  a_sample_len: assert property (p_sample_len)
    else $error("sample longer than selected time");

endmodule : tsc_ctrl

/* test/tsc_front_model.sv */
// model of the eight sense electrodes and their converter
// assumes the bench says which inputs are touched and picks the base level
module tsc_front_model (
  // clock
  input wire logic ref_clk,
  // bench control
  input wire logic [7:0] touch_req,
  input wire logic [15:0] base,
  // controller side
  input wire logic sample_active,
  input wire logic [2:0] sample_chan,
  output logic [7:0] touch_detect,
  output logic [15:0] sample_value
);
  timeunit 1ns;
  timeprecision 100ps;

  // touch level follows the finger directly
  assign touch_detect = touch_req;

  // idle converter output toggles so a stale value never looks valid
  initial sample_value = 16'h0000;

  // level per channel is fixed, so each average equals that level
  always @(posedge ref_clk) begin
    if (sample_active) begin
      sample_value <= base + 16'(sample_chan) * 16'h0111;
    end else begin
      sample_value <= ~sample_value;
    end
  end
endmodule : tsc_front_model

/* test/tb_top.sv */
// self-checking bench for the touch sampling controller
// assumes a tick of one clock, so every timed count is in clocks
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int UNIT = int'(tsc_pkg::UNIT_TICKS);
  // clock, reset, register port
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  // front end and results
  logic [7:0] touch_req = 8'h00;
  logic [7:0] touch_detect;
  logic [15:0] sample_value;
  logic sample_active, low_power, meas_valid, irq;
  logic [2:0] sample_chan, meas_chan;
  logic [15:0] meas_value;
  logic [7:0] press_hold, plain_touch, base_invalid;
  // bench state; skip hides cycles right after a reconfiguration
  int mismatches = 0;
  int n_tests = 0;
  int cyc_cnt = 0;
  int skip = 2;
  int last_fall = 0;
  int last_mv = 0;
  int n_plain = 0;
  int samples_per_measure_code = 3, sel = 1, cyc = 1, hc, rc, t0;
  logic lp_q = 1'b1;
  logic [2:0] exp_ch = 3'h0;
  logic [31:0] seed = 32'h0000001A;
  logic [15:0] base = 16'h0000;
  logic [7:0] en = 8'hFF;
  logic [7:0] rd_val;

  tsc_ctrl #(.TICK_CYCLES(1)) uut (
    .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .touch_detect(touch_detect),
    .sample_value(sample_value), .sample_active(sample_active),
    .sample_chan(sample_chan), .low_power(low_power),
    .meas_valid(meas_valid), .meas_chan(meas_chan),
    .meas_value(meas_value), .press_hold(press_hold),
    .plain_touch(plain_touch), .base_invalid(base_invalid), .irq(irq)
  );

  tsc_front_model fe (
    .ref_clk(ref_clk), .touch_req(touch_req), .base(base),
    .sample_active(sample_active), .sample_chan(sample_chan),
    .touch_detect(touch_detect), .sample_value(sample_value)
  );

  // 40 MHz clock
  always #12.5 ref_clk = ~ref_clk;

  // clocks since reset release
  always @(posedge ref_clk) cyc_cnt <= rst ? 0 : cyc_cnt + 1;

  // repeatable pseudo random source
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  // clocks for one averaged measurement
  function automatic int meas_t();
    int s;
    s = sel ? int'(tsc_pkg::SAMP_SHORT_TICKS) : int'(tsc_pkg::SAMP_LONG_TICKS);
    return (1 << samples_per_measure_code) * s;
  endfunction : meas_t

  // cycle length: programmed period unless sampling runs longer
  function automatic int cyc_t();
    int p, t;
    p = (cyc + 1) * UNIT;
    t = $countones(en) * meas_t();
    return (t > p) ? t : p;
  endfunction : cyc_t

  // next enabled channel after from, wrapping
  function automatic logic [2:0] next_en(input logic [2:0] from);
    for (int k = 1; k <= 8; k++) begin
      if (en[(int'(from) + k) % 8]) return 3'((int'(from) + k) % 8);
    end
    return from;
  endfunction : next_en

  function automatic logic [15:0] exp_val(input logic [2:0] ch);
    return base + 16'(ch) * 16'h0111;
  endfunction : exp_val

  task automatic chk(input string what, input logic [15:0] e,
                     input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  // timing compare with a few clocks of slack for pipeline stages
  task automatic near(input string what, input int e, input int g);
    n_tests++;
    if (g < e - 4 || g > e + 4) begin
      mismatches++;
      $display("BAD %s expected %0d seen %0d", what, e, g);
    end
  endtask : near

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // data stands only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e,
                        input string what);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(posedge ref_clk);
    rd_val = reg_rdata;
    chk(what, 16'(e), 16'(rd_val));
  endtask : rd_chk

  task automatic wait_to(input int t);
    while (cyc_cnt < t) @(posedge ref_clk);
  endtask : wait_to

  task automatic wrap_up();
    if (mismatches == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : wrap_up

  // sampling monitor: cycle length, channel order, averages
  always @(posedge ref_clk) begin
    if (!rst && lp_q && !low_power) begin
      if (skip == 0 && last_fall > 0)
        near("cycle_len", cyc_t(), cyc_cnt - last_fall);
      if (skip > 0) skip--;
      last_fall = cyc_cnt;
      last_mv = cyc_cnt;
      exp_ch = next_en(3'h7);
    end
    if (!rst && meas_valid === 1'b1 && skip == 0) begin
      chk("meas_chan", 16'(exp_ch), 16'(meas_chan));
      chk("meas_value", exp_val(exp_ch), meas_value);
      near("meas_time", meas_t(), cyc_cnt - last_mv);
      last_mv = cyc_cnt;
      exp_ch = next_en(exp_ch);
    end
    // converter channel stays on the expected input between results
    if (!rst && skip == 0 && sample_active === 1'b1)
      chk("sample_chan", 16'(exp_ch), 16'(sample_chan));
    if (plain_touch[0] === 1'b1) n_plain++;
    lp_q = low_power;
  end

  // watchdog well past the longest expected run
  initial begin
    repeat (100000) @(posedge ref_clk);
    mismatches++;
    wrap_up();
  end

  // main sequence
  initial begin
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    rd_chk(tsc_pkg::ADDR_HOLD, 8'h07, "hold_rst");
    rd_chk(tsc_pkg::ADDR_AVG, 8'h1D, "avg_rst");
    rd_chk(tsc_pkg::ADDR_RECAL, 8'hFF, "recal_rst");
    rd_chk(8'h25, 8'h00, "unmapped");
    chk("base_inv_rst", 16'h00FF, 16'(base_invalid));
    wr(tsc_pkg::ADDR_RECAL, 8'h00);
    rd_chk(tsc_pkg::ADDR_RECAL, 8'hFF, "recal_keep");
    wr(tsc_pkg::ADDR_HOLD, 8'hFF);
    rd_chk(tsc_pkg::ADDR_HOLD, 8'h0F, "hold_resv");
    // random sampling and timing setup
    base = 16'(xs());
    samples_per_measure_code = int'(xs() % 3);
    sel = int'(xs() % 2);
    cyc = int'(xs() % 2);
    en = 8'(xs()) | 8'h01;
    hc = int'(xs() % 3);
    rc = int'(xs() % 2);
    wr(tsc_pkg::ADDR_SENS_EN, en);
    wr(tsc_pkg::ADDR_AVG, 8'((samples_per_measure_code << 3) | (sel << 2) | cyc));
    skip = 2;
    wr(tsc_pkg::ADDR_HOLD, 8'(hc));
    wr(tsc_pkg::ADDR_SENS_CFG, 8'hA0 | 8'(rc));
    wr(tsc_pkg::ADDR_MASK, 8'h00);
    // a press on input 7 while it recalibrates restarts its quiet wait
    wait_to(1000);
    touch_req <= 8'h80;
    repeat (20) @(posedge ref_clk);
    touch_req <= 8'h00;
    wait_to(59950);
    chk("recal_busy", 16'h00FF, 16'(base_invalid));
    wait_to(60100);
    chk("recal_done", 16'h0080, 16'(base_invalid));
    rd_chk(tsc_pkg::ADDR_RECAL, 8'h80, "recal_reg");
    rd_chk(tsc_pkg::ADDR_STATUS, 8'h00, "recal_quiet");
    wait_to(61200);
    chk("recal_retry", 16'h0000, 16'(base_invalid));
    // one channel with more samples than the period holds
    // hide results before the model's settings change under them
    skip = 2;
    en = 8'h01;
    samples_per_measure_code = 5;
    sel = 1;
    cyc = 0;
    wr(tsc_pkg::ADDR_SENS_EN, en);
    // shorten samples only between samples, never inside a long one
    while (low_power !== 1'b1) @(posedge ref_clk);
    wr(tsc_pkg::ADDR_AVG, 8'h2C);
    // short touch, then mask and clear of its event
    touch_req <= 8'h01;
    repeat (50) @(posedge ref_clk);
    n_plain = 0;
    touch_req <= 8'h00;
    repeat (10) @(posedge ref_clk);
    chk("plain_pulse", 16'd1, 16'(n_plain));
    chk("press_plain", 16'h0000, 16'(press_hold));
    rd_chk(tsc_pkg::ADDR_STATUS, 8'h01, "touch_evt");
    chk("irq_masked", 16'h0000, 16'(irq));
    wr(tsc_pkg::ADDR_MASK, 8'h01);
    repeat (2) @(posedge ref_clk);
    chk("irq_on", 16'h0001, 16'(irq));
    wr(tsc_pkg::ADDR_STATUS, 8'h01);
    repeat (2) @(posedge ref_clk);
    chk("irq_off", 16'h0000, 16'(irq));
    rd_chk(tsc_pkg::ADDR_STATUS, 8'h00, "evt_clr");
    // press and hold across the threshold, then one repeat
    t0 = cyc_cnt;
    touch_req <= 8'h01;
    wait_to(t0 + (hc + 1) * UNIT - 10);
    chk("hold_early", 16'h0000, 16'(press_hold));
    wait_to(t0 + (hc + 1) * UNIT + 10);
    chk("hold_late", 16'h0001, 16'(press_hold));
    wr(tsc_pkg::ADDR_STATUS, 8'h01);
    wait_to(t0 + (hc + rc + 2) * UNIT - 10);
    rd_chk(tsc_pkg::ADDR_STATUS, 8'h00, "rpt_early");
    wait_to(t0 + (hc + rc + 2) * UNIT + 10);
    rd_chk(tsc_pkg::ADDR_STATUS, 8'h01, "rpt_evt");
    chk("irq_rpt", 16'h0001, 16'(irq));
    wr(tsc_pkg::ADDR_STATUS, 8'h01);
    n_plain = 0;
    touch_req <= 8'h00;
    repeat (10) @(posedge ref_clk);
    chk("release_plain", 16'h0000, 16'(n_plain));
    chk("release_hold", 16'h0000, 16'(press_hold));
    rd_chk(tsc_pkg::ADDR_STATUS, 8'h00, "release_evt");
    // let the stretched cycles be measured
    wait_to(cyc_cnt + 9000);
    wrap_up();
  end
endmodule : tb_top
